// [hdl/pdl_defines.svh]
`ifndef PDL_DEFINES_SVH
`define PDL_DEFINES_SVH

`define PDL_CLK_PERIOD_NS 10
`define PDL_TIMEOUT_NS 100000
`define PDL_TIMEOUT_CYC (`PDL_TIMEOUT_NS / `PDL_CLK_PERIOD_NS)
`define PDL_TMR_W 16

`define PDL_AW 8
`define PDL_DW 16
`define PDL_TW 4
`define PDL_NCHAN 4
`define PDL_CIDX_W 3
`define PDL_FIFO_DEPTH 4
`define PDL_TX_W (2 * `PDL_AW + `PDL_TW + `PDL_DW)

`define PDL_SEG_DIR_BIT 15
`define PDL_SEG_CNT_HI 11
`define PDL_CNT_W 12

`define PDL_ACK 16'h0001
`define PDL_NAK 16'h0000

`define PDL_IRQ_LOCK_OK 3'h1
`define PDL_IRQ_LOCK_ACK 3'h2
`define PDL_IRQ_LOCK_NAK 3'h3
`define PDL_IRQ_TIMEOUT 3'h4
`define PDL_IRQ_SEG_OK 3'h5
`define PDL_IRQ_SEG_BAD 3'h6

`endif

// [hdl/pdl_pkg.sv]
package pdl_pkg;
  typedef enum logic [3:0] {
    PDL_MSG_LOCKON_REQ,
    PDL_MSG_LOCKON_RSP,
    PDL_MSG_CHAN_VERIFY,
    PDL_MSG_LOCKON_NOTIFY,
    PDL_MSG_LOCKON_TERM,
    PDL_MSG_PARAM_LOAD,
    PDL_MSG_DATA_WORD,
    PDL_MSG_CHECK_WORD,
    PDL_MSG_CHECK_NAK
  } pdl_msg_t;

  typedef enum logic [2:0] {
    PDL_A_IDLE,
    PDL_A_WAIT_RSP,
    PDL_A_WAIT_VERIFY,
    PDL_A_LOCKED,
    PDL_A_STREAM,
    PDL_A_SEND_CHECK,
    PDL_A_WAIT_CHECK
  } pdl_act_t;

  typedef enum logic [2:0] {
    PDL_P_IDLE,
    PDL_P_SCAN,
    PDL_P_LOCKED,
    PDL_P_RECV
  } pdl_pas_t;
endpackage : pdl_pkg

// [hdl/pdl_fifo.sv]
`timescale 1ns/1ps
module pdl_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  assign o_in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign o_out_valid = (cnt_q != '0);
  assign push = i_in_valid & o_in_ready;
  assign pop = o_out_valid & i_out_ready;
  assign o_out_data = mem_q[rd_q];

  always_ff @(posedge i_core_clk) begin
    if (push) begin
      mem_q[wr_q] <= i_in_data;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : pdl_fifo

// [hdl/pdl_timer.sv]
`timescale 1ns/1ps
`include "pdl_defines.svh"
module pdl_timer #(
  parameter logic [`PDL_TMR_W-1:0] CYCLES = `PDL_TMR_W'(`PDL_TIMEOUT_CYC)
) (
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic i_start,
  input wire logic i_stop,
  output logic o_expired
);
  logic [`PDL_TMR_W-1:0] cnt_q;
  logic run_q;

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      cnt_q <= '0;
      run_q <= 1'b0;
      o_expired <= 1'b0;
    end else begin
      o_expired <= 1'b0;
      if (i_stop) begin
        run_q <= 1'b0;
      end else if (i_start) begin
        cnt_q <= CYCLES;
        run_q <= 1'b1;
      end else if (run_q) begin
        if (cnt_q <= `PDL_TMR_W'(1)) begin
          run_q <= 1'b0;
          o_expired <= 1'b1;
        end else begin
          cnt_q <= cnt_q - 1'b1;
        end
      end
    end
  end
endmodule : pdl_timer

// [hdl/pdl_engine.sv]
`timescale 1ns/1ps
`include "pdl_defines.svh"
module pdl_engine
  import pdl_pkg::*;
#(
  parameter logic [`PDL_TMR_W-1:0] TIMEOUT_CYCLES =
    `PDL_TMR_W'(`PDL_TIMEOUT_CYC)
) (
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic i_lockon_request_enable,
  input wire logic i_lockon_start,
  input wire logic i_dialogue_end,
  input wire logic [`PDL_AW-1:0] i_target_addr,
  input wire logic [`PDL_AW-1:0] i_target_route,
  input wire logic [`PDL_AW-1:0] i_own_addr,
  input wire logic [`PDL_AW-1:0] i_own_route,
  input wire logic [`PDL_DW-1:0] i_req_chan,
  input wire logic [`PDL_NCHAN*`PDL_DW-1:0] i_chan_list,
  input wire logic [`PDL_CIDX_W-1:0] i_chan_count,
  input wire logic i_seg_start,
  input wire logic [`PDL_DW-1:0] i_seg_ctl,
  input wire logic [`PDL_DW-1:0] i_seg_addr,
  input wire logic i_msg_valid,
  output logic o_msg_ready,
  input wire logic [`PDL_TW-1:0] i_msg_type,
  input wire logic [`PDL_DW-1:0] i_msg_data,
  output logic o_tx_valid,
  input wire logic i_tx_ready,
  output logic [`PDL_AW-1:0] o_tx_addr,
  output logic [`PDL_AW-1:0] o_tx_route,
  output logic [`PDL_TW-1:0] o_tx_type,
  output logic [`PDL_DW-1:0] o_tx_data,
  input wire logic i_mem_valid,
  output logic o_mem_ready,
  input wire logic [`PDL_DW-1:0] i_mem_data,
  output logic o_mem_wr,
  output logic [`PDL_DW-1:0] o_mem_wr_data,
  output logic [`PDL_DW-1:0] o_dma_addr,
  output logic [`PDL_CNT_W-1:0] o_dma_count,
  output logic o_dma_dir,
  output logic [`PDL_AW-1:0] o_pas_dest_addr,
  output logic [`PDL_AW-1:0] o_pas_dest_route,
  output logic [`PDL_AW-1:0] o_act_dest_addr,
  output logic [`PDL_AW-1:0] o_act_dest_route,
  output logic o_chan_store,
  output logic [`PDL_DW-1:0] o_chan_value,
  output logic o_passive_avail,
  output logic o_act_irq,
  output logic [2:0] o_act_irq_code,
  output logic o_pas_irq,
  output logic [2:0] o_pas_irq_code
);
  pdl_act_t act_q;
  pdl_pas_t pas_q;
  logic [`PDL_DW-1:0] chan_w [`PDL_NCHAN];
  logic [`PDL_CIDX_W-1:0] scan_q;
  logic [`PDL_DW-1:0] req_q;
  logic [`PDL_CNT_W-1:0] act_cnt_q;
  logic [`PDL_DW-1:0] act_sum_q;
  logic [`PDL_DW-1:0] pas_sum_q;
  logic act_push;
  logic pas_push;
  logic pas_grant;
  logic [`PDL_TW-1:0] act_type;
  logic [`PDL_DW-1:0] act_data;
  logic [`PDL_TW-1:0] pas_type;
  logic [`PDL_DW-1:0] pas_data;
  logic fifo_ready;
  logic [`PDL_TX_W-1:0] fifo_in;
  logic act_start;
  logic act_stop;
  logic act_expired;
  logic pas_start;
  logic pas_stop;
  logic pas_expired;
  logic rx_req;
  logic rx_rsp;
  logic rx_verify;
  logic rx_notify;
  logic rx_term;
  logic rx_param;
  logic rx_word;
  logic rx_check;
  logic rx_cnak;
  logic scan_hit;
  logic scan_last;

  genvar gi;
  generate
    for (gi = 0; gi < `PDL_NCHAN; gi++) begin : g_chan
      assign chan_w[gi] = i_chan_list[gi*`PDL_DW +: `PDL_DW];
    end
  endgenerate

  assign o_msg_ready = 1'b1;
  assign rx_req = i_msg_valid & (i_msg_type == PDL_MSG_LOCKON_REQ);
  assign rx_rsp = i_msg_valid & (i_msg_type == PDL_MSG_LOCKON_RSP);
  assign rx_verify = i_msg_valid & (i_msg_type == PDL_MSG_CHAN_VERIFY);
  assign rx_notify = i_msg_valid & (i_msg_type == PDL_MSG_LOCKON_NOTIFY);
  assign rx_term = i_msg_valid & (i_msg_type == PDL_MSG_LOCKON_TERM);
  assign rx_param = i_msg_valid & (i_msg_type == PDL_MSG_PARAM_LOAD);
  assign rx_word = i_msg_valid & (i_msg_type == PDL_MSG_DATA_WORD);
  assign rx_check = i_msg_valid & (i_msg_type == PDL_MSG_CHECK_WORD);
  assign rx_cnak = i_msg_valid & (i_msg_type == PDL_MSG_CHECK_NAK);

  assign scan_hit = (chan_w[scan_q[`PDL_CIDX_W-2:0]] == req_q);
  assign scan_last = (scan_q + 1'b1 >= i_chan_count) |
    (scan_q == `PDL_CIDX_W'(`PDL_NCHAN - 1));

  // Active side message source; the active end wins the shared FIFO
  always_comb begin
    act_push = 1'b0;
    act_type = PDL_MSG_LOCKON_REQ;
    act_data = '0;
    case (act_q)
      PDL_A_IDLE: begin
        act_push = i_lockon_start;
        act_data = {i_own_addr, i_own_route};
      end
      PDL_A_WAIT_RSP: begin
        act_push = rx_rsp;
        act_data = i_req_chan;
        act_type = (i_msg_data == i_req_chan) ? PDL_MSG_LOCKON_NOTIFY
                                              : PDL_MSG_CHAN_VERIFY;
      end
      PDL_A_LOCKED: begin
        act_push = i_seg_start;
        act_type = PDL_MSG_PARAM_LOAD;
        act_data = i_seg_ctl;
      end
      PDL_A_STREAM: begin
        act_push = i_mem_valid;
        act_type = PDL_MSG_DATA_WORD;
        act_data = i_mem_data;
      end
      PDL_A_SEND_CHECK: begin
        act_push = 1'b1;
        act_type = PDL_MSG_CHECK_WORD;
        act_data = act_sum_q;
      end
      default: begin
        act_push = 1'b0;
      end
    endcase
  end

  always_comb begin
    pas_push = 1'b0;
    pas_type = PDL_MSG_LOCKON_RSP;
    pas_data = '0;
    case (pas_q)
      PDL_P_IDLE: begin
        pas_push = rx_req & i_lockon_request_enable;
        pas_data = chan_w[0];
      end
      PDL_P_SCAN: begin
        pas_push = scan_hit | scan_last;
        pas_type = PDL_MSG_LOCKON_TERM;
        pas_data = scan_hit ? `PDL_ACK : `PDL_NAK;
      end
      PDL_P_RECV: begin
        pas_push = rx_check & (i_msg_data != pas_sum_q);
        pas_type = PDL_MSG_CHECK_NAK;
      end
      default: begin
        pas_push = 1'b0;
      end
    endcase
  end

  assign pas_grant = fifo_ready & ~act_push;
  assign o_mem_ready = (act_q == PDL_A_STREAM) & fifo_ready;
  assign fifo_in = act_push ?
    {o_act_dest_addr, o_act_dest_route, act_type, act_data} :
    {o_pas_dest_addr, o_pas_dest_route, pas_type, pas_data};

  pdl_fifo #(
    .WIDTH(`PDL_TX_W),
    .DEPTH(`PDL_FIFO_DEPTH)
  ) u_tx_fifo (
    .i_core_clk(i_core_clk),
    .i_reset(i_reset),
    .i_in_valid(act_push | pas_push),
    .o_in_ready(fifo_ready),
    .i_in_data(fifo_in),
    .o_out_valid(o_tx_valid),
    .i_out_ready(i_tx_ready),
    .o_out_data({o_tx_addr, o_tx_route, o_tx_type, o_tx_data})
  );

  // Active timer control
  always_comb begin
    act_start = 1'b0;
    act_stop = i_dialogue_end;
    case (act_q)
      PDL_A_IDLE: act_start = i_lockon_start & fifo_ready;
      PDL_A_WAIT_RSP: begin
        act_stop = rx_rsp & ~fifo_ready;
        act_start = rx_rsp & fifo_ready;
      end
      PDL_A_WAIT_VERIFY: act_start = rx_term & (i_msg_data == `PDL_ACK);
      PDL_A_LOCKED: begin
        act_stop = i_seg_start & ~(i_seg_ctl[`PDL_SEG_DIR_BIT] &
          fifo_ready);
        act_start = i_seg_start & fifo_ready & i_seg_ctl[`PDL_SEG_DIR_BIT];
      end
      PDL_A_STREAM: act_stop = 1'b1;
      PDL_A_SEND_CHECK: act_start = fifo_ready;
      default: act_start = 1'b0;
    endcase
  end

  // Passive timer control
  always_comb begin
    pas_start = 1'b0;
    pas_stop = i_dialogue_end;
    case (pas_q)
      PDL_P_IDLE: pas_start = pas_push & pas_grant;
      PDL_P_SCAN: pas_start = scan_hit & pas_grant;
      PDL_P_LOCKED: pas_start = rx_notify;
      PDL_P_RECV: pas_start = rx_check & (pas_grant | ~pas_push);
      default: pas_start = 1'b0;
    endcase
  end

  pdl_timer #(
    .CYCLES(TIMEOUT_CYCLES)
  ) u_act_timer (
    .i_core_clk(i_core_clk),
    .i_reset(i_reset),
    .i_start(act_start),
    .i_stop(act_stop),
    .o_expired(act_expired)
  );

  pdl_timer #(
    .CYCLES(TIMEOUT_CYCLES)
  ) u_pas_timer (
    .i_core_clk(i_core_clk),
    .i_reset(i_reset),
    .i_start(pas_start),
    .i_stop(pas_stop),
    .o_expired(pas_expired)
  );

  // Active state machine
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      act_q <= PDL_A_IDLE;
      o_act_dest_addr <= '0;
      o_act_dest_route <= '0;
    end else if (i_dialogue_end | act_expired) begin
      act_q <= PDL_A_IDLE;
    end else begin
      case (act_q)
        PDL_A_IDLE: begin
          if (i_lockon_start) begin
            o_act_dest_addr <= i_target_addr;
            o_act_dest_route <= i_target_route;
          end
          if (i_lockon_start & fifo_ready) begin
            act_q <= PDL_A_WAIT_RSP;
          end
        end
        PDL_A_WAIT_RSP: begin
          if (rx_rsp & fifo_ready) begin
            act_q <= (i_msg_data == i_req_chan) ? PDL_A_LOCKED
                                                : PDL_A_WAIT_VERIFY;
          end
        end
        PDL_A_WAIT_VERIFY: begin
          if (rx_term) begin
            act_q <= (i_msg_data == `PDL_ACK) ? PDL_A_LOCKED
                                              : PDL_A_IDLE;
          end
        end
        PDL_A_LOCKED: begin
          if (i_seg_start & fifo_ready) begin
            act_q <= i_seg_ctl[`PDL_SEG_DIR_BIT] ? PDL_A_STREAM
                                                 : PDL_A_LOCKED;
            if (i_seg_ctl[`PDL_SEG_CNT_HI:0] == '0 &
                i_seg_ctl[`PDL_SEG_DIR_BIT]) begin
              act_q <= PDL_A_SEND_CHECK;
            end
          end
        end
        PDL_A_STREAM: begin
          if (i_mem_valid & fifo_ready & act_cnt_q == `PDL_CNT_W'(1)) begin
            act_q <= PDL_A_SEND_CHECK;
          end
        end
        PDL_A_SEND_CHECK: begin
          if (fifo_ready) begin
            act_q <= PDL_A_WAIT_CHECK;
          end
        end
        PDL_A_WAIT_CHECK: begin
          if (rx_cnak) begin
            act_q <= PDL_A_LOCKED;
          end
        end
        default: act_q <= PDL_A_IDLE;
      endcase
    end
  end

  // Active DMA count, address and check word
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      act_cnt_q <= '0;
      act_sum_q <= '0;
      o_dma_addr <= '0;
      o_dma_count <= '0;
      o_dma_dir <= 1'b0;
    end else if (act_q == PDL_A_LOCKED & i_seg_start & fifo_ready) begin
      act_cnt_q <= i_seg_ctl[`PDL_SEG_CNT_HI:0];
      act_sum_q <= '0;
      o_dma_addr <= i_seg_addr;
      o_dma_count <= i_seg_ctl[`PDL_SEG_CNT_HI:0];
      o_dma_dir <= i_seg_ctl[`PDL_SEG_DIR_BIT];
    end else if (act_q == PDL_A_STREAM & i_mem_valid & fifo_ready) begin
      act_cnt_q <= act_cnt_q - 1'b1;
      act_sum_q <= act_sum_q + i_mem_data;
      o_dma_addr <= o_dma_addr + 1'b1;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      o_act_irq <= 1'b0;
      o_act_irq_code <= '0;
    end else begin
      o_act_irq <= 1'b0;
      if (act_expired & act_q != PDL_A_IDLE) begin
        o_act_irq <= 1'b1;
        o_act_irq_code <= `PDL_IRQ_TIMEOUT;
      end else if (act_q == PDL_A_WAIT_RSP & rx_rsp & fifo_ready &
                   i_msg_data == i_req_chan) begin
        o_act_irq <= 1'b1;
        o_act_irq_code <= `PDL_IRQ_LOCK_OK;
      end else if (act_q == PDL_A_WAIT_VERIFY & rx_term) begin
        o_act_irq <= 1'b1;
        o_act_irq_code <= (i_msg_data == `PDL_ACK) ? `PDL_IRQ_LOCK_ACK
                                                   : `PDL_IRQ_LOCK_NAK;
      end else if (act_q == PDL_A_WAIT_CHECK & rx_cnak) begin
        o_act_irq <= 1'b1;
        o_act_irq_code <= `PDL_IRQ_SEG_BAD;
      end
    end
  end

  // Passive state machine and availability
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      pas_q <= PDL_P_IDLE;
      o_passive_avail <= 1'b1;
      scan_q <= '0;
      req_q <= '0;
      o_pas_dest_addr <= '0;
      o_pas_dest_route <= '0;
    end else if (i_dialogue_end | pas_expired) begin
      pas_q <= PDL_P_IDLE;
      o_passive_avail <= 1'b1;
    end else begin
      case (pas_q)
        PDL_P_IDLE: begin
          if (o_passive_avail & pas_push & pas_grant) begin
            o_pas_dest_addr <= i_msg_data[`PDL_DW-1:`PDL_AW];
            o_pas_dest_route <= i_msg_data[`PDL_AW-1:0];
            o_passive_avail <= 1'b0;
            pas_q <= PDL_P_LOCKED;
          end
        end
        PDL_P_LOCKED: begin
          if (rx_verify) begin
            req_q <= i_msg_data;
            scan_q <= `PDL_CIDX_W'(1);
            pas_q <= PDL_P_SCAN;
          end else if (rx_param) begin
            pas_q <= PDL_P_RECV;
          end
        end
        PDL_P_SCAN: begin
          if (pas_push & pas_grant) begin
            pas_q <= scan_hit ? PDL_P_LOCKED : PDL_P_IDLE;
            o_passive_avail <= ~scan_hit;
          end else if (~pas_push) begin
            scan_q <= scan_q + 1'b1;
          end
        end
        PDL_P_RECV: begin
          if (rx_check & (pas_grant | ~pas_push)) begin
            pas_q <= PDL_P_LOCKED;
          end
        end
        default: pas_q <= PDL_P_IDLE;
      endcase
    end
  end

  // Passive memory store, check word and channel store
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      pas_sum_q <= '0;
      o_mem_wr <= 1'b0;
      o_mem_wr_data <= '0;
      o_chan_store <= 1'b0;
      o_chan_value <= '0;
    end else begin
      o_mem_wr <= 1'b0;
      o_chan_store <= 1'b0;
      if (pas_q == PDL_P_LOCKED & rx_param) begin
        pas_sum_q <= '0;
      end else if (pas_q == PDL_P_RECV & rx_word) begin
        o_mem_wr <= 1'b1;
        o_mem_wr_data <= i_msg_data;
        pas_sum_q <= pas_sum_q + i_msg_data;
      end
      if (pas_q == PDL_P_LOCKED & rx_notify) begin
        o_chan_store <= 1'b1;
        o_chan_value <= i_msg_data;
      end else if (pas_q == PDL_P_SCAN & scan_hit & pas_grant) begin
        o_chan_store <= 1'b1;
        o_chan_value <= req_q;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      o_pas_irq <= 1'b0;
      o_pas_irq_code <= '0;
    end else begin
      o_pas_irq <= 1'b0;
      if (pas_expired & pas_q != PDL_P_IDLE) begin
        o_pas_irq <= 1'b1;
        o_pas_irq_code <= `PDL_IRQ_TIMEOUT;
      end else if ((pas_q == PDL_P_LOCKED & rx_notify) |
                   (pas_q == PDL_P_SCAN & scan_hit & pas_grant)) begin
        o_pas_irq <= 1'b1;
        o_pas_irq_code <= `PDL_IRQ_LOCK_OK;
      end else if (pas_q == PDL_P_RECV & rx_check &
                   i_msg_data == pas_sum_q) begin
        o_pas_irq <= 1'b1;
        o_pas_irq_code <= `PDL_IRQ_SEG_OK;
      end
    end
  end
endmodule : pdl_engine

// [sim/pdl_chk.sv]
`timescale 1ns/1ps
`include "pdl_defines.svh"
module pdl_chk
  import pdl_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic i_lockon_request_enable,
  input wire logic i_msg_valid,
  input wire logic [`PDL_TW-1:0] i_msg_type,
  input wire logic [`PDL_DW-1:0] i_msg_data,
  input wire logic o_tx_valid,
  input wire logic [`PDL_TW-1:0] o_tx_type,
  input wire logic [`PDL_DW-1:0] o_tx_data,
  input wire logic o_mem_wr,
  input wire logic [`PDL_DW-1:0] o_mem_wr_data,
  input wire logic o_dma_dir,
  input wire logic o_chan_store,
  input wire logic o_passive_avail,
  input wire logic o_act_irq,
  input wire logic [2:0] o_act_irq_code,
  input wire logic o_pas_irq,
  input wire logic [2:0] o_pas_irq_code
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_reset);
  logic rx_req;
  assign rx_req = i_msg_valid && i_msg_type == PDL_MSG_LOCKON_REQ;
  sequence s_nak_rx;
    i_msg_valid && i_msg_type == PDL_MSG_LOCKON_TERM && i_msg_data == 0;
  endsequence
  property p_req_taken;
    rx_req && i_lockon_request_enable && o_passive_avail |=> !o_passive_avail;
  endproperty
  a_req_taken: assert property (p_req_taken) else $error("avail kept");
  property p_refuse;
    rx_req && !i_lockon_request_enable |=> $stable(o_passive_avail);
  endproperty
  a_refuse: assert property (p_refuse) else $error("answered");
  property p_pas_code;
    o_pas_irq |-> o_pas_irq_code inside {1, 4, 5};
  endproperty
  a_pas_code: assert property (p_pas_code) else $error("pas code");
  property p_chan_irq;
    o_chan_store |-> o_pas_irq && o_pas_irq_code == `PDL_IRQ_LOCK_OK;
  endproperty
  a_chan_irq: assert property (p_chan_irq) else $error("no irq");
  property p_nak_code;
    s_nak_rx ##1 o_act_irq |-> o_act_irq_code == `PDL_IRQ_LOCK_NAK;
  endproperty
  a_nak_code: assert property (p_nak_code) else $error("nak code");
  property p_mem_wr;
    o_mem_wr |-> $past(i_msg_type) == PDL_MSG_DATA_WORD
      && o_mem_wr_data == $past(i_msg_data);
  endproperty
  a_mem_wr: assert property (p_mem_wr) else $error("bad store");
  property p_dir;
    o_tx_valid && o_tx_type == PDL_MSG_DATA_WORD |-> o_dma_dir;
  endproperty
  a_dir: assert property (p_dir) else $error("bad dir");
  property p_nak_avail;
    o_tx_valid && o_tx_type == PDL_MSG_LOCKON_TERM && o_tx_data == 0
      |-> o_passive_avail;
  endproperty
  a_nak_avail: assert property (p_nak_avail) else $error("unavail");
endmodule : pdl_chk
bind pdl_engine pdl_chk pdl_chk_inst (.i_core_clk, .i_reset,
  .i_lockon_request_enable, .i_msg_valid, .i_msg_type, .i_msg_data,
  .o_tx_valid, .o_tx_type, .o_tx_data, .o_mem_wr, .o_mem_wr_data,
  .o_dma_dir, .o_chan_store, .o_passive_avail, .o_act_irq,
  .o_act_irq_code, .o_pas_irq, .o_pas_irq_code);

// [sim/pdl_peer_model.sv]
`timescale 1ns/1ps
`include "pdl_defines.svh"
module pdl_peer_model (
  input wire logic i_core_clk,
  input wire logic i_stall,
  input wire logic i_tx_valid,
  output logic o_tx_ready,
  input wire logic [`PDL_TW-1:0] i_tx_type,
  input wire logic [`PDL_DW-1:0] i_tx_data,
  output logic o_msg_valid,
  output logic [`PDL_TW-1:0] o_msg_type,
  output logic [`PDL_DW-1:0] o_msg_data
);
  logic [19:0] q[$];
  initial begin
    o_msg_valid = 1'b0;
    o_msg_type = '1;
    o_msg_data = '0;
  end
  assign o_tx_ready = !i_stall;
  // Peer takes each bus word
  always @(posedge i_core_clk) begin
    if (i_tx_valid && o_tx_ready) q.push_back({i_tx_type, i_tx_data});
  end
  // One bus write, then lines scrambled
  task automatic send(input logic [3:0] t, input logic [15:0] d);
    @(negedge i_core_clk);
    o_msg_valid = 1'b1;
    o_msg_type = t;
    o_msg_data = d;
    @(negedge i_core_clk);
    o_msg_valid = 1'b0;
    o_msg_type = ~t;
    o_msg_data = ~d;
  endtask : send
endmodule : pdl_peer_model

// [sim/tb.sv]
`timescale 1ns/1ps
`include "pdl_defines.svh"
module tb;
  import pdl_pkg::*;
  localparam int TO = 60;
  int fail_count = 0;
  int n_checks = 0;
  logic clk, rst, en, lst, dend, sst, mv, stall, msr;
  logic tv, trdy, mvl, mrdy, pav, air, pir, ddir;
  logic [3:0] mt, tt;
  logic [2:0] ac, pc;
  logic [2:0] aq[$], pq[$];
  logic [7:0] ta, tr, oa, orr, pda, pdr, ada, adr;
  logic [15:0] rch, sct, sad, md, td, mdat, mwd, chv, dad;
  logic [63:0] chl;
  logic [11:0] dcnt;
  pdl_engine #(.TIMEOUT_CYCLES(16'(TO))) pdl_engine_inst (
    .i_core_clk(clk), .i_reset(rst), .i_lockon_request_enable(en),
    .i_lockon_start(lst), .i_dialogue_end(dend), .i_target_addr(ta),
    .i_target_route(tr), .i_own_addr(oa), .i_own_route(orr),
    .i_req_chan(rch), .i_chan_list(chl), .i_chan_count(3'd4),
    .i_seg_start(sst), .i_seg_ctl(sct), .i_seg_addr(sad),
    .i_msg_valid(mvl), .o_msg_ready(msr), .i_msg_type(mt), .i_msg_data(md),
    .o_tx_valid(tv), .i_tx_ready(trdy), .o_tx_addr(), .o_tx_route(),
    .o_tx_type(tt), .o_tx_data(td), .i_mem_valid(mv), .o_mem_ready(mrdy),
    .i_mem_data(mdat), .o_mem_wr(), .o_mem_wr_data(mwd), .o_dma_addr(dad),
    .o_dma_count(dcnt), .o_dma_dir(ddir), .o_pas_dest_addr(pda),
    .o_pas_dest_route(pdr), .o_act_dest_addr(ada), .o_act_dest_route(adr),
    .o_chan_store(), .o_chan_value(chv), .o_passive_avail(pav),
    .o_act_irq(air), .o_act_irq_code(ac), .o_pas_irq(pir),
    .o_pas_irq_code(pc));
  pdl_peer_model pm (.i_core_clk(clk), .i_stall(stall), .i_tx_valid(tv),
    .o_tx_ready(trdy), .i_tx_type(tt), .i_tx_data(td), .o_msg_valid(mvl),
    .o_msg_type(mt), .o_msg_data(md));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (air) aq.push_back(ac);
    if (pir) pq.push_back(pc);
    if (mv && mrdy) mdat <= mdat + 16'h0001;
  end
  task automatic test_done;
    if (fail_count == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : test_done
  task automatic chk(input string n, input logic [15:0] e, g);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic tx(input logic [3:0] t, input logic [15:0] d, input bit cd);
    logic [19:0] w;
    for (int k = 0; k < 80 && pm.q.size() == 0; k++) @(negedge clk);
    if (pm.q.size() == 0) begin
      chk("tx_wait", 16'h0001, 16'h0000);
      test_done();
    end
    w = pm.q.pop_front();
    chk("tx_type", 16'(t), 16'(w[19:16]));
    if (cd) chk("tx_data", d, w[15:0]);
  endtask : tx
  task automatic irq(input bit p, input logic [2:0] c);
    logic [2:0] g;
    for (int k = 0; k < 100 && (p ? pq.size() : aq.size()) == 0; k++)
      @(negedge clk);
    if ((p ? pq.size() : aq.size()) == 0) begin
      chk("irq_wait", 16'h0001, 16'h0000);
      test_done();
    end
    g = p ? pq.pop_front() : aq.pop_front();
    chk("irq_code", 16'(c), 16'(g));
  endtask : irq
  task automatic pulse(ref logic s);
    @(negedge clk);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask : pulse
  task automatic lock(input logic [15:0] c);
    pulse(lst);
    tx(PDL_MSG_LOCKON_REQ, {oa, orr}, 1);
    pm.send(PDL_MSG_LOCKON_RSP, c);
  endtask : lock
  task automatic t_refuse;
    en = 1'b0;
    pm.send(PDL_MSG_LOCKON_REQ, 16'h5a3c);
    repeat (5) @(negedge clk);
    chk("tx_count", 16'h0000, 16'(pm.q.size()));
    chk("avail", 16'h0001, 16'(pav));
    en = 1'b1;
  endtask : t_refuse
  task automatic t_pas_first;
    pm.send(PDL_MSG_LOCKON_REQ, 16'h5a3c);
    tx(PDL_MSG_LOCKON_RSP, chl[15:0], 1);
    chk("dest", 16'h5a3c, {pda, pdr});
    chk("avail", 16'h0000, 16'(pav));
    pm.send(PDL_MSG_LOCKON_NOTIFY, chl[15:0]);
    irq(1, `PDL_IRQ_LOCK_OK);
    chk("chan", chl[15:0], chv);
    pm.send(PDL_MSG_PARAM_LOAD, 16'h8002);
    pm.send(PDL_MSG_DATA_WORD, 16'h1234);
    pm.send(PDL_MSG_DATA_WORD, 16'h4321);
    chk("wr_data", 16'h4321, mwd);
    pm.send(PDL_MSG_CHECK_WORD, 16'h0000);
    tx(PDL_MSG_CHECK_NAK, 16'h0000, 0);
    chk("pas_irqs", 16'h0000, 16'(pq.size()));
    pulse(dend);
  endtask : t_pas_first
  task automatic t_pas_scan;
    pm.send(PDL_MSG_LOCKON_REQ, 16'h0102);
    tx(PDL_MSG_LOCKON_RSP, chl[15:0], 1);
    pm.send(PDL_MSG_CHAN_VERIFY, chl[63:48]);
    tx(PDL_MSG_LOCKON_TERM, `PDL_ACK, 1);
    irq(1, `PDL_IRQ_LOCK_OK);
    chk("chan", chl[63:48], chv);
    pulse(dend);
    pm.send(PDL_MSG_LOCKON_REQ, 16'h0102);
    tx(PDL_MSG_LOCKON_RSP, chl[15:0], 1);
    pm.send(PDL_MSG_CHAN_VERIFY, 16'hdead);
    tx(PDL_MSG_LOCKON_TERM, `PDL_NAK, 1);
    repeat (3) @(negedge clk);
    chk("avail", 16'h0001, 16'(pav));
    chk("pas_irqs", 16'h0000, 16'(pq.size()));
  endtask : t_pas_scan
  task automatic t_act;
    pulse(lst);
    tx(PDL_MSG_LOCKON_REQ, {oa, orr}, 1);
    chk("act_dest", {ta, tr}, {ada, adr});
    repeat (TO - 10) @(negedge clk);
    chk("act_irqs", 16'h0000, 16'(aq.size()));
    irq(0, `PDL_IRQ_TIMEOUT);
    lock(16'hbeef);
    tx(PDL_MSG_CHAN_VERIFY, rch, 1);
    pm.send(PDL_MSG_LOCKON_TERM, `PDL_NAK);
    irq(0, `PDL_IRQ_LOCK_NAK);
    repeat (TO + 5) @(negedge clk);
    chk("act_irqs", 16'h0000, 16'(aq.size()));
    lock(16'hbeef);
    tx(PDL_MSG_CHAN_VERIFY, rch, 1);
    pm.send(PDL_MSG_LOCKON_TERM, `PDL_ACK);
    irq(0, `PDL_IRQ_LOCK_ACK);
    pulse(dend);
    lock(rch);
    tx(PDL_MSG_LOCKON_NOTIFY, rch, 1);
    irq(0, `PDL_IRQ_LOCK_OK);
  endtask : t_act
  task automatic t_seg;
    stall = 1'b1;
    mv = 1'b1;
    pulse(sst);
    repeat (8) @(negedge clk);
    chk("mem_ready", 16'h0000, 16'(mrdy));
    chk("dma_dir", 16'h0001, 16'(ddir));
    chk("dma_count", 16'h0005, 16'(dcnt));
    // FIFO holds the control word and three data words while stalled
    chk("dma_addr", sad + 16'(`PDL_FIFO_DEPTH - 1), dad);
    stall = 1'b0;
    tx(PDL_MSG_PARAM_LOAD, sct, 1);
    for (int k = 0; k < 5; k++) tx(PDL_MSG_DATA_WORD, 16'h0100 + 16'(k), 1);
    tx(PDL_MSG_CHECK_WORD, 16'h050a, 1);
    pm.send(PDL_MSG_CHECK_NAK, 16'h0000);
    irq(0, `PDL_IRQ_SEG_BAD);
    mv = 1'b0;
  endtask : t_seg
  initial begin
    {rst, en} = 2'b11;
    {lst, dend, sst, mv, stall} = 5'h00;
    {ta, tr, oa, orr} = 32'h2143_6587;
    {rch, sct, sad, mdat} = 64'h0e55_8005_0200_0100;
    chl = 64'h0d44_0c33_0b22_0a11;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    chk("avail", 16'h0001, 16'(pav));
    t_refuse();
    t_pas_first();
    t_pas_scan();
    t_act();
    t_seg();
    test_done();
  end
endmodule : tb
